// ==== logic/ksc_top.sv ====
// Summary of operation
// RQ1: Enable low stops kernel, blocks most accesses
// RQ2: Software reads config back after enabling
// RQ3: Enable changes only with its protect bit
// RQ4: Normal-mode field bits 5:4 selects mode
// RQ5: Suspend-mode field bits 9:8, same coding
// RQ6: Clock-off-mode field bits 13:12, same coding
// RQ7: Protect bits 7,11,15 gate each field
// RQ8: Reserved bits read zero
// RQ9: Insensitive block ignores stop modes
// RQ10: Sensitive block honours applied stop mode
// RQ11: Application reset clears normal, clock-off fields
// RQ12: Suspend field cleared only by debug reset
// RQ13: System operating mode picks applied field
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module ksc_top
  import ksc_pkg::*;
(
  // Clock and resets
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic dbg_resetn,
  // AXI4-Lite write address
  input wire logic [KSC_AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [KSC_DW-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [KSC_AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [KSC_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Device operating mode from the system, same clock
  input wire logic [1:0] sys_op_mode,
  // Kernel controls
  output logic kernel_clk_en,
  output logic [1:0] applied_mode_ff,
  output logic [KSC_NBLK-1:0] blk_run,
  output logic [KSC_NBLK-1:0] blk_stop1
);

  // Register state
  logic module_enable_bit_ff; // Kernel on/off
  logic [1:0] normal_mode_field_ff; // Mode in normal operation
  logic [1:0] suspend_mode_field_ff; // Mode in suspend
  logic [1:0] clock_off_mode_field_ff; // Mode in clock-off
  logic [KSC_NBLK-1:0] stop_sens_ff; // One bit per kernel block

  // Write channel capture
  logic aw_held_ff;
  logic w_held_ff;
  logic [KSC_AW-1:0] awaddr_ff;
  logic [KSC_DW-1:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic wr_fire; // Both halves present, response slot free
  logic wr_cfg; // Write hits the configuration register
  logic wr_sens; // Write hits the sensitivity register, kernel on

  // Read channel state
  logic rvalid_ff;
  logic [KSC_DW-1:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic ar_fire;

  // Unused protection attributes
  logic unused_prot;
  assign unused_prot = ^{s_axi_awprot, s_axi_arprot};

  // Classify an address: 0 unmapped, 1 config, 2 sensitivity
  function automatic logic [1:0] decode(input logic [KSC_AW-1:0] a);
    if (a == KSC_CFG_ADDR) begin
      return 2'h1;
    end else if (a == KSC_SENS_ADDR) begin
      return 2'h2;
    end else begin
      return 2'h0;
    end
  endfunction

  // Read image of the configuration register, protect bits read zero
  function automatic logic [KSC_DW-1:0] cfg_image(
    input logic en, input logic [1:0] nom,
    input logic [1:0] sum, input logic [1:0] com);
    logic [KSC_DW-1:0] v;
    v = '0;
    v[KSC_MODULE_ENABLE_BIT_BIT] = en;
    v[KSC_NOM_LSB +: 2] = nom;
    v[KSC_SUM_LSB +: 2] = sum;
    v[KSC_COM_LSB +: 2] = com;
    return v;
  endfunction

  // Handshake outputs
  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready = !w_held_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // Write and read strobes
  assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
  assign ar_fire = s_axi_arvalid && !rvalid_ff;
  assign wr_cfg = wr_fire && (decode(awaddr_ff) == 2'h1);
  // Kernel off: sensitivity writes are dropped
  assign wr_sens = wr_fire && (decode(awaddr_ff) == 2'h2) && module_enable_bit_ff; // RQ1

  // Address and data captured in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      awaddr_ff <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_ff <= 1'b1;
      awaddr_ff <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_ff <= 1'b0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_ff <= 1'b1;
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_ff <= 1'b0;
    end
  end

  // Write response; unmapped or refused writes answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= KSC_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= (wr_cfg || wr_sens) ? KSC_RESP_OKAY : KSC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Module enable: needs its protect bit in the same write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      module_enable_bit_ff <= KSC_MODULE_ENABLE_BIT_RST;
    end else if (wr_cfg && wstrb_ff[0] && wdata_ff[KSC_MODULE_ENABLE_PROTECT_BIT]) begin // RQ3
      module_enable_bit_ff <= wdata_ff[KSC_MODULE_ENABLE_BIT_BIT];
    end
  end

  // Normal and clock-off fields follow the application reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      normal_mode_field_ff <= KSC_MODE_RST; // RQ11
      clock_off_mode_field_ff <= KSC_MODE_RST; // RQ11
    end else begin
      if (wr_cfg && wstrb_ff[0] && wdata_ff[KSC_NORMAL_MODE_PROTECT_BIT]) begin // RQ7
        normal_mode_field_ff <= wdata_ff[KSC_NOM_LSB +: 2]; // RQ4
      end
      if (wr_cfg && wstrb_ff[1] && wdata_ff[KSC_CLOCK_OFF_MODE_PROTECT_BIT]) begin // RQ7
        clock_off_mode_field_ff <= wdata_ff[KSC_COM_LSB +: 2]; // RQ6
      end
    end
  end

  // Suspend field survives an application reset so a debugger keeps it
  always_ff @(posedge aclk) begin
    if (!dbg_resetn) begin
      suspend_mode_field_ff <= KSC_MODE_RST; // RQ12
    end else if (aresetn && wr_cfg && wstrb_ff[1] && wdata_ff[KSC_SUSPEND_MODE_PROTECT_BIT]) begin // RQ7
      suspend_mode_field_ff <= wdata_ff[KSC_SUM_LSB +: 2]; // RQ5
    end
  end

  // Sensitivity bits, low byte only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stop_sens_ff <= KSC_SENS_RST;
    end else if (wr_sens && wstrb_ff[0]) begin
      stop_sens_ff <= wdata_ff[KSC_NBLK-1:0];
    end
  end

  // Read data; kernel off leaves only the configuration register visible
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= KSC_RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_ff <= 1'b1;
      case (decode(s_axi_araddr))
        2'h1: begin
          // Protect and reserved positions read zero
          rdata_ff <= cfg_image(module_enable_bit_ff, normal_mode_field_ff,
                                suspend_mode_field_ff, clock_off_mode_field_ff); // RQ8
          rresp_ff <= KSC_RESP_OKAY;
        end
        2'h2: begin
          if (module_enable_bit_ff) begin
            rdata_ff <= {{(KSC_DW-KSC_NBLK){1'b0}}, stop_sens_ff}; // RQ8
            rresp_ff <= KSC_RESP_OKAY;
          end else begin
            rdata_ff <= '0; // RQ1
            rresp_ff <= KSC_RESP_SLVERR;
          end
        end
        default: begin
          rdata_ff <= '0;
          rresp_ff <= KSC_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // Applied mode from system operating mode; frozen while kernel is off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      applied_mode_ff <= KSC_KM_RUN0;
    end else if (module_enable_bit_ff) begin // RQ1
      case (sys_op_mode)
        KSC_OPM_SUSPEND: applied_mode_ff <= suspend_mode_field_ff; // RQ13
        KSC_OPM_CLKOFF: applied_mode_ff <= clock_off_mode_field_ff; // RQ13
        default: applied_mode_ff <= normal_mode_field_ff; // RQ13
      endcase
    end
  end

  // Kernel clock gate follows the enable directly
  assign kernel_clk_en = module_enable_bit_ff; // RQ1

  // One stop gate per kernel block
  genvar gi;
  generate
    for (gi = 0; gi < KSC_NBLK; gi++) begin : g_blk
      ksc_stop_gate u_gate (
        .aclk(aclk),
        .aresetn(aresetn),
        .kernel_on(module_enable_bit_ff),
        .stop_sensitive(stop_sens_ff[gi]),
        .applied_mode(applied_mode_ff),
        .blk_run_ff(blk_run[gi]),
        .blk_stop1_ff(blk_stop1[gi])
      );
    end
  endgenerate

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_cfg_write;
    wr_cfg && wstrb_ff[0];
  endsequence
  sequence s_sens_read_off;
    ar_fire && decode(s_axi_araddr) == 2'h2 && !module_enable_bit_ff;
  endsequence

  property p_module_enable_bit_hold;
    s_cfg_write ##0 !wdata_ff[KSC_MODULE_ENABLE_PROTECT_BIT]
      |=> $stable(module_enable_bit_ff);
  endproperty
  a_module_enable_bit_hold: assert property (p_module_enable_bit_hold) else $error("enable moved without protect"); // RQ3

  property p_module_enable_bit_set;
    s_cfg_write ##0 wdata_ff[KSC_MODULE_ENABLE_PROTECT_BIT]
      |=> module_enable_bit_ff == $past(wdata_ff[KSC_MODULE_ENABLE_BIT_BIT]);
  endproperty
  a_module_enable_bit_set: assert property (p_module_enable_bit_set) else $error("enable not updated"); // RQ3

  property p_nom_set;
    s_cfg_write ##0 wdata_ff[KSC_NORMAL_MODE_PROTECT_BIT]
      |=> normal_mode_field_ff == $past(wdata_ff[KSC_NOM_LSB +: 2]);
  endproperty
  a_nom_set: assert property (p_nom_set) else $error("normal field not written"); // RQ4

  property p_com_keep;
    wr_cfg && !wdata_ff[KSC_CLOCK_OFF_MODE_PROTECT_BIT] |=> $stable(clock_off_mode_field_ff);
  endproperty
  a_com_keep: assert property (p_com_keep) else $error("clock-off field moved"); // RQ7

  property p_cfg_reserved;
    ar_fire && decode(s_axi_araddr) == 2'h1 |=> rvalid_ff
      && rdata_ff[15:14] == 2'h0 && rdata_ff[11:10] == 2'h0
      && rdata_ff[7:6] == 2'h0 && rdata_ff[3:1] == 3'h0;
  endproperty
  a_cfg_reserved: assert property (p_cfg_reserved) else $error("reserved bit set"); // RQ8

  property p_off_read;
    s_sens_read_off |=> rvalid_ff && rdata_ff == '0 && rresp_ff == KSC_RESP_SLVERR;
  endproperty
  a_off_read: assert property (p_off_read) else $error("read served while off"); // RQ1

  property p_off_blocks;
    !module_enable_bit_ff |=> blk_run == '0;
  endproperty
  a_off_blocks: assert property (p_off_blocks) else $error("block runs while off"); // RQ1

  property p_applied;
    module_enable_bit_ff && sys_op_mode == KSC_OPM_SUSPEND
      |=> applied_mode_ff == $past(suspend_mode_field_ff);
  endproperty
  a_applied: assert property (p_applied) else $error("suspend field not applied"); // RQ13

  property p_insens;
    module_enable_bit_ff && !stop_sens_ff[0] |=> blk_run[0];
  endproperty
  a_insens: assert property (p_insens) else $error("insensitive block stopped"); // RQ9

  property p_sens_stop;
    module_enable_bit_ff && stop_sens_ff[0] && applied_mode_ff[1]
      |=> !blk_run[0] && blk_stop1[0] == $past(applied_mode_ff[0]);
  endproperty
  a_sens_stop: assert property (p_sens_stop) else $error("stop mode ignored"); // RQ10

endmodule

// ==== logic/ksc_pkg.sv ====
package ksc_pkg;
  // Bus geometry
  localparam int KSC_AW = 8;
  localparam int KSC_DW = 32;
  // Register indices as printed; byte address is four times the index
  localparam logic [5:0] KSC_CFG_IDX = 6'h00;
  localparam logic [5:0] KSC_SENS_IDX = 6'h0E;
  localparam logic [7:0] KSC_CFG_ADDR = {KSC_CFG_IDX, 2'b00};
  localparam logic [7:0] KSC_SENS_ADDR = {KSC_SENS_IDX, 2'b00};
  // Configuration register field positions
  localparam int KSC_MODULE_ENABLE_BIT_BIT = 0;
  localparam int KSC_MODULE_ENABLE_PROTECT_BIT = 1;
  localparam int KSC_NOM_LSB = 4;
  localparam int KSC_NORMAL_MODE_PROTECT_BIT = 7;
  localparam int KSC_SUM_LSB = 8;
  localparam int KSC_SUSPEND_MODE_PROTECT_BIT = 11;
  localparam int KSC_COM_LSB = 12;
  localparam int KSC_CLOCK_OFF_MODE_PROTECT_BIT = 15;
  // Number of stop-sensitive kernel blocks
  localparam int KSC_NBLK = 4;
  // Reset values
  localparam logic KSC_MODULE_ENABLE_BIT_RST = 1'b0;
  localparam logic [1:0] KSC_MODE_RST = 2'h0;
  localparam logic [3:0] KSC_SENS_RST = 4'h0;
  // Kernel mode encoding
  localparam logic [1:0] KSC_KM_RUN0 = 2'h0;
  localparam logic [1:0] KSC_KM_RUN1 = 2'h1;
  localparam logic [1:0] KSC_KM_STOP0 = 2'h2;
  localparam logic [1:0] KSC_KM_STOP1 = 2'h3;
  // Device operating mode indication from the system
  localparam logic [1:0] KSC_OPM_NORMAL = 2'h0;
  localparam logic [1:0] KSC_OPM_SUSPEND = 2'h1;
  localparam logic [1:0] KSC_OPM_CLKOFF = 2'h2;
  // AXI responses
  localparam logic [1:0] KSC_RESP_OKAY = 2'h0;
  localparam logic [1:0] KSC_RESP_SLVERR = 2'h2;
  // Stop modes are the ones with the high bit set
  function automatic logic ksc_is_stop(input logic [1:0] mode);
    return mode[1];
  endfunction
endpackage

// ==== logic/ksc_stop_gate.sv ====
`timescale 1ns/1ps
module ksc_stop_gate
  import ksc_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Controls
  input wire logic kernel_on,
  input wire logic stop_sensitive,
  input wire logic [1:0] applied_mode,
  // Block state
  output logic blk_run_ff,
  output logic blk_stop1_ff
);
  // Run unless kernel is off, or block obeys an applied stop mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blk_run_ff <= 1'b0;
      blk_stop1_ff <= 1'b0;
    end else if (!kernel_on) begin
      // Switched off at once, no stop condition honoured
      blk_run_ff <= 1'b0;
      blk_stop1_ff <= 1'b0;
    end else if (stop_sensitive && ksc_is_stop(applied_mode)) begin
      blk_run_ff <= 1'b0; // RQ10
      blk_stop1_ff <= (applied_mode == KSC_KM_STOP1);
    end else begin
      // Insensitive block behaves as in run mode 0
      blk_run_ff <= 1'b1; // RQ9
      blk_stop1_ff <= 1'b0;
    end
  end
endmodule

// ==== verif/ksc_tb.sv ====
`timescale 1ns/1ps
module tb
  import ksc_pkg::*;
;
  // Clock, resets and system mode
  logic aclk, aresetn, dbg_resetn;
  logic [1:0] sys_op_mode;
  // AXI4-Lite master side
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  // Kernel outputs
  logic kernel_clk_en;
  logic [1:0] applied_mode_ff;
  logic [3:0] blk_run, blk_stop1;
  // Scoreboard state: expected {resp, data} notes
  logic [33:0] rq[$], bq[$];
  logic [33:0] rexp, bexp;
  int error_cnt = 0, checks = 0, seed = 71;
  logic [3:0] sens;

  ksc_top ksc_top_inst (.aclk(aclk), .aresetn(aresetn), .dbg_resetn(dbg_resetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(s_axi_arprot), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .sys_op_mode(sys_op_mode), .kernel_clk_en(kernel_clk_en),
    .applied_mode_ff(applied_mode_ff), .blk_run(blk_run), .blk_stop1(blk_stop1));

  // 10 MHz clock
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // Single comparison point
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Verdict and end of run
  task end_of_test;
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Write: both halves offered together, each dropped at its own handshake
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
    logic ta, tw, da, dw, got;
    bq.push_back({r, 32'h0000_0000});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    da = 1'b0;
    dw = 1'b0;
    while (!(da && dw)) begin
      // Sample readies in the low half, where they are settled
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      da = da | ta;
      dw = dw | tw;
    end
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      got = s_axi_bvalid;
      @(posedge aclk);
    end while (!got);
    s_axi_bready <= 1'b0;
  endtask

  // Read: rready held from the start so the answer is taken at once
  task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ta, got;
    rq.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      @(posedge aclk);
    end while (!ta);
    s_axi_arvalid <= 1'b0;
    do begin
      @(negedge aclk);
      got = s_axi_rvalid;
      @(posedge aclk);
    end while (!got);
    s_axi_rready <= 1'b0;
    // Let an edge pass so a following read never re-raises rready in this step
    @(posedge aclk);
  endtask

  // Select an operating mode and compare the kernel outputs after they settle
  task kchk(input logic [1:0] op, input logic [1:0] m, input logic [3:0] s);
    logic [3:0] er, es;
    sys_op_mode <= op;
    er = ~(s & {4{m[1]}});
    es = s & {4{m[1] & m[0]}};
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    chk({32'h0000_0000, applied_mode_ff}, {32'h0000_0000, m});
    chk({30'h0000_0000, blk_run}, {30'h0000_0000, er});
    chk({30'h0000_0000, blk_stop1}, {30'h0000_0000, es});
    @(posedge aclk);
  endtask

  // Monitor: each answer is matched against the oldest note
  always @(negedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      rexp = rq.pop_front();
      chk({s_axi_rresp, s_axi_rdata}, rexp);
    end
    if (s_axi_bvalid && s_axi_bready) begin
      bexp = bq.pop_front();
      chk({s_axi_bresp, 32'h0000_0000}, bexp);
    end
  end

  // Watchdog sized well above the few hundred cycles the tests need
  initial begin
    #3000000;
    error_cnt++;
    end_of_test();
  end

  // Main sequence
  initial begin
    aresetn = 1'b0;
    dbg_resetn = 1'b0;
    sys_op_mode = KSC_OPM_NORMAL;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    dbg_resetn <= 1'b1;
    @(posedge aclk);
    // Disabled: sensitivity is neither read nor written
    rd(KSC_CFG_ADDR, 32'h0000_0000, KSC_RESP_OKAY);
    rd(KSC_SENS_ADDR, 32'h0000_0000, KSC_RESP_SLVERR);
    wr(KSC_SENS_ADDR, 32'h0000_000F, 4'hF, KSC_RESP_SLVERR);
    // Enable without its protect bit has no effect
    wr(KSC_CFG_ADDR, 32'h0000_0001, 4'hF, KSC_RESP_OKAY);
    rd(KSC_CFG_ADDR, 32'h0000_0000, KSC_RESP_OKAY);
    wr(KSC_CFG_ADDR, 32'h0000_0003, 4'hF, KSC_RESP_OKAY);
    rd(KSC_CFG_ADDR, 32'h0000_0001, KSC_RESP_OKAY);
    chk({33'h0, kernel_clk_en}, 34'h1);
    rd(KSC_SENS_ADDR, 32'h0000_0000, KSC_RESP_OKAY);
    // Every code in every field; reserved bits kept at zero as software must
    for (int i = 0; i < 4; i++) begin
      sens = 4'($random(seed));
      wr(KSC_CFG_ADDR, {16'h0, 2'b10, 2'(i + 2), 2'b10, 2'(i + 1), 2'b10, 2'(i), 4'h3},
        4'hF, KSC_RESP_OKAY);
      rd(KSC_CFG_ADDR, {16'h0, 2'b00, 2'(i + 2), 2'b00, 2'(i + 1), 2'b00, 2'(i), 4'h1},
        KSC_RESP_OKAY);
      wr(KSC_SENS_ADDR, {28'h0, sens}, 4'hF, KSC_RESP_OKAY);
      rd(KSC_SENS_ADDR, {28'h0, sens}, KSC_RESP_OKAY);
      kchk(KSC_OPM_NORMAL, 2'(i), sens);
      kchk(KSC_OPM_SUSPEND, 2'(i + 1), sens);
      kchk(KSC_OPM_CLKOFF, 2'(i + 2), sens);
      kchk(2'h3, 2'(i), sens);
    end
    // Only the suspend field carries its protect bit here
    wr(KSC_CFG_ADDR, 32'h0000_3A30, 4'hF, KSC_RESP_OKAY);
    rd(KSC_CFG_ADDR, 32'h0000_1231, KSC_RESP_OKAY);
    kchk(KSC_OPM_NORMAL, 2'h3, sens);
    // Disable: kernel off, mode frozen, sensitivity locked
    wr(KSC_CFG_ADDR, 32'h0000_0002, 4'hF, KSC_RESP_OKAY);
    sys_op_mode <= KSC_OPM_SUSPEND;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    chk({33'h0, kernel_clk_en}, 34'h0);
    chk({30'h0, blk_run}, 34'h0);
    chk({32'h0, applied_mode_ff}, 34'h3);
    @(posedge aclk);
    rd(KSC_CFG_ADDR, 32'h0000_1230, KSC_RESP_OKAY);
    wr(KSC_SENS_ADDR, 32'h0000_0000, 4'hF, KSC_RESP_SLVERR);
    rd(KSC_SENS_ADDR, 32'h0000_0000, KSC_RESP_SLVERR);
    // Unmapped word refused
    wr(8'h04, 32'h0000_FFFF, 4'hF, KSC_RESP_SLVERR);
    rd(8'h04, 32'h0000_0000, KSC_RESP_SLVERR);
    // Application reset keeps the suspend field
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(KSC_CFG_ADDR, 32'h0000_0200, KSC_RESP_OKAY);
    wr(KSC_CFG_ADDR, 32'h0000_BBB3, 4'hF, KSC_RESP_OKAY);
    rd(KSC_CFG_ADDR, 32'h0000_3331, KSC_RESP_OKAY);
    rd(KSC_SENS_ADDR, 32'h0000_0000, KSC_RESP_OKAY);
    // Debug reset clears only the suspend field
    dbg_resetn <= 1'b0;
    repeat (2) @(posedge aclk);
    dbg_resetn <= 1'b1;
    @(posedge aclk);
    rd(KSC_CFG_ADDR, 32'h0000_3031, KSC_RESP_OKAY);
    repeat (2) @(posedge aclk);
    end_of_test();
  end
endmodule
